// file: include/prcp_pkg.sv
// Package of constants and types for the paged register control port host.
package prcp_pkg;

  // Link timing: the host makes the serial clock by dividing its own clock.
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned LINK_PERIOD_NS = 800;
  localparam int unsigned QTR_CYC = LINK_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);

  // Software register byte offsets.
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_TXD = 8'h04;
  localparam logic [7:0] OFS_RXD = 8'h08;
  localparam logic [7:0] OFS_STS = 8'h0c;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] CMD_RESET = 32'h0000_0000;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // Serial protocol constants.
  localparam logic [4:0] I2C_ADDR_HI = 5'h13;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;
  localparam logic [7:0] READ_FILL = 8'hff;
  localparam logic [3:0] BIT_LAST_SPI = 4'h7;
  localparam logic [3:0] BIT_LAST_I2C = 4'h8;
  localparam logic [1:0] PH_0 = 2'h0;
  localparam logic [1:0] PH_1 = 2'h1;
  localparam logic [1:0] PH_2 = 2'h2;
  localparam logic [1:0] PH_3 = 2'h3;

  // Device page numbers.
  localparam logic [7:0] PAGE_CONFIG = 8'h00;
  localparam logic [7:0] PAGE_COEF_FIRST = 8'h02;
  localparam logic [7:0] PAGE_COEF_LAST = 8'h04;

  // Device register map, page 0.
  localparam logic [6:0] DEV_PAGE_SELECT = 7'h00;
  localparam logic [6:0] DEV_SOFT_RESET_CONTROL = 7'h01;
  localparam logic [6:0] DEV_SLEEP_CONTROL = 7'h02;
  localparam logic [6:0] DEV_SHUTDOWN_CONFIG = 7'h05;
  localparam logic [6:0] DEV_AUDIO_PORT_CONFIG0 = 7'h07;
  localparam logic [6:0] DEV_AUDIO_PORT_CONFIG1 = 7'h08;
  localparam logic [6:0] DEV_AUDIO_PORT_CONFIG2 = 7'h09;
  localparam logic [6:0] DEV_CHANNEL1_SLOT_CONFIG = 7'h0b;
  localparam logic [6:0] DEV_CHANNEL2_SLOT_CONFIG = 7'h0c;
  localparam logic [6:0] DEV_CHANNEL3_SLOT_CONFIG = 7'h0d;
  localparam logic [6:0] DEV_CHANNEL4_SLOT_CONFIG = 7'h0e;
  localparam logic [6:0] DEV_CHANNEL5_SLOT_CONFIG = 7'h0f;
  localparam logic [6:0] DEV_CHANNEL6_SLOT_CONFIG = 7'h10;
  localparam logic [6:0] DEV_CHANNEL7_SLOT_CONFIG = 7'h11;
  localparam logic [6:0] DEV_CHANNEL8_SLOT_CONFIG = 7'h12;
  localparam logic [6:0] DEV_CLOCK_MASTER_CONFIG0 = 7'h13;
  localparam logic [6:0] DEV_CLOCK_MASTER_CONFIG1 = 7'h14;
  localparam logic [6:0] DEV_AUDIO_BUS_CLOCK_MONITOR = 7'h15;
  localparam logic [6:0] DEV_CLOCK_SOURCE_SELECT = 7'h16;
  localparam logic [6:0] DEV_DENSITY_MIC_CLOCK_GEN = 7'h1f;
  localparam logic [6:0] DEV_DENSITY_MIC_SAMPLE_EDGE = 7'h20;
  localparam logic [6:0] DEV_GENERAL_IO_CONFIG0 = 7'h21;
  localparam logic [6:0] DEV_OUTPUT_PIN_CONFIG0 = 7'h22;
  localparam logic [6:0] DEV_OUTPUT_PIN_CONFIG1 = 7'h23;
  localparam logic [6:0] DEV_OUTPUT_PIN_CONFIG2 = 7'h24;
  localparam logic [6:0] DEV_OUTPUT_PIN_CONFIG3 = 7'h25;
  localparam logic [6:0] DEV_OUTPUT_PIN_VALUE = 7'h29;
  localparam logic [6:0] DEV_IO_PIN_MONITOR = 7'h2a;
  localparam logic [6:0] DEV_INPUT_PIN_CONFIG0 = 7'h2b;
  localparam logic [6:0] DEV_INPUT_PIN_CONFIG1 = 7'h2c;

  // Command register layout.
  typedef struct packed {
    logic [18:0] rsvd;
    logic [1:0] strap;
    logic i2c;
    logic [1:0] len_m1;
    logic rd;
    logic [6:0] reg_addr;
  } prcp_cmd_s;

  // Status register layout.
  typedef struct packed {
    logic [28:0] rsvd;
    logic done;
    logic nack;
    logic busy;
  } prcp_sts_s;

  // Pins driven toward the device.
  typedef struct packed {
    logic slave_select_n;
    logic sclk;
    logic mosi;
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } prcp_pins_s;

  // Pins read from the device side.
  typedef struct packed {
    logic miso;
    logic scl_i;
    logic sda_i;
  } prcp_pin_in_s;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_START = 4'h2,
    ST_BIT = 4'h4,
    ST_STOP = 4'h8
  } prcp_state_e;

  typedef enum logic [1:0] {
    STG_ADDR = 2'h0,
    STG_REG = 2'h1,
    STG_RADDR = 2'h2,
    STG_DATA = 2'h3
  } prcp_stage_e;

endpackage

// file: core/prcp_host.sv
// Host controller that drives the paged register control port over SPI or I2C.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/100ps
// Functional notes
// - I2C read begins with write of register address
// - Repeated start with read bit; device returns data
// - Single read ends with not-acknowledge then stop
// - Multi read: acknowledge all but last byte
// - SPI clock polarity 0, phase 1, select low
// - Command holds seven-bit address then direction bit
// - SPI write: direction 0, then data byte
// - Select held low for whole sequential burst
// - Page select written at register 0 anytime
// - Host avoids reserved pages, registers and bits (this host sends any page and register address unchecked)
module prcp_host (
  // Clock, enable and reset.
  input wire logic clock,
  input wire logic ce,
  input wire logic sys_rst,
  // Register bus write channels.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Register bus read channels.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Device pins.
  input wire prcp_pkg::prcp_pin_in_s pins_in,
  output prcp_pkg::prcp_pins_s pins
);

  ////////////////////////////////////////////////////////////////////////////
  prcp_pkg::prcp_pin_in_s sync1_r;
  prcp_pkg::prcp_pin_in_s in_s;
  prcp_pkg::prcp_pins_s pins_r;
  prcp_pkg::prcp_state_e state_r;
  prcp_pkg::prcp_stage_e stage_r;
  prcp_pkg::prcp_stage_e stage_nxt;
  prcp_pkg::prcp_cmd_s cmd_r;
  logic [3:0][7:0] txd_r;
  logic [3:0][7:0] rxd_r;
  logic [7:0] qcnt_r;
  logic [1:0] ph_r;
  logic [3:0] bit_r;
  logic [1:0] cnt_r;
  logic [7:0] sh_r;
  logic [7:0] rxsh_r;
  logic nack_r;
  logic done_r;
  logic go_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic busy;
  logic qtick;
  logic stall;
  logic adv;
  logic rx_data;
  logic last_data;
  logic [3:0] bit_last;
  logic tx_bit;
  logic sbit;
  logic byte_end;
  logic cap;
  logic [7:0] cap_byte;
  logic wr_fire;
  logic cmd_ok;
  logic [31:0] rd_val;
  logic rd_map;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] m;
    m = o;
    for (int i = 0; i < 4; i++)
    begin
      if (s[i])
      begin
        m[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // Byte that goes out for a given stage and data index.
  function automatic logic [7:0] byte_of(input prcp_pkg::prcp_stage_e stg,
                                         input logic [1:0] idx,
                                         input prcp_pkg::prcp_cmd_s c,
                                         input logic [3:0][7:0] tx);
    logic [7:0] b;
    case (stg)
      prcp_pkg::STG_ADDR: b = {prcp_pkg::I2C_ADDR_HI, c.strap, prcp_pkg::DIR_WRITE};
      prcp_pkg::STG_RADDR: b = {prcp_pkg::I2C_ADDR_HI, c.strap, prcp_pkg::DIR_READ};
      // Address goes out unchecked; software keeps to valid pages and registers.
      prcp_pkg::STG_REG: b = c.i2c ? {1'b0, c.reg_addr} : {c.reg_addr, c.rd};
      default: b = c.rd ? prcp_pkg::READ_FILL : tx[idx];
    endcase
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin inputs cross into the clock domain through two flip-flops.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      sync1_r <= '0;
      in_s <= '0;
    end
    else if (ce)
    begin
      sync1_r <= pins_in;
      in_s <= sync1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign busy = (state_r != prcp_pkg::ST_IDLE) || go_r;
  assign qtick = (qcnt_r == prcp_pkg::QTR_LAST);
  // A device holding SCL low stretches the high phase.
  assign stall = cmd_r.i2c && (ph_r == prcp_pkg::PH_2) && !in_s.scl_i;
  assign adv = qtick && !stall && (state_r != prcp_pkg::ST_IDLE);
  assign rx_data = (stage_r == prcp_pkg::STG_DATA) && cmd_r.rd;
  assign last_data = (cnt_r == cmd_r.len_m1);
  assign bit_last = cmd_r.i2c ? prcp_pkg::BIT_LAST_I2C : prcp_pkg::BIT_LAST_SPI;
  // Ninth I2C bit: acknowledge received bytes, release on the last one.
  assign tx_bit = (bit_r == prcp_pkg::BIT_LAST_I2C) ? (rx_data ? last_data : 1'b1) : sh_r[7];
  assign sbit = cmd_r.i2c ? in_s.sda_i : in_s.miso;
  assign byte_end = adv && (state_r == prcp_pkg::ST_BIT) && (ph_r == prcp_pkg::PH_3)
                    && (bit_r == bit_last);
  assign cap = byte_end && rx_data;
  assign cap_byte = cmd_r.i2c ? rxsh_r : {rxsh_r[6:0], sbit};

  always_comb
  begin
    case (stage_r)
      prcp_pkg::STG_ADDR: stage_nxt = prcp_pkg::STG_REG;
      prcp_pkg::STG_REG: stage_nxt = (cmd_r.i2c && cmd_r.rd) ? prcp_pkg::STG_RADDR
                                                              : prcp_pkg::STG_DATA;
      default: stage_nxt = prcp_pkg::STG_DATA;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial sequencer: quarter-period phases build each bit.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_r <= prcp_pkg::ST_IDLE;
      stage_r <= prcp_pkg::STG_ADDR;
      pins_r <= '0;
      pins_r.slave_select_n <= 1'b1;
      qcnt_r <= '0;
      ph_r <= prcp_pkg::PH_0;
      bit_r <= '0;
      cnt_r <= '0;
      sh_r <= '0;
      rxsh_r <= '0;
      nack_r <= 1'b0;
      done_r <= 1'b0;
    end
    else if (ce)
    begin
      if (state_r == prcp_pkg::ST_IDLE || qtick && !stall)
      begin
        qcnt_r <= '0;
      end
      else if (!qtick)
      begin
        qcnt_r <= qcnt_r + 8'h01;
      end
      if (adv)
      begin
        ph_r <= ph_r + 2'h1;
      end
      case (state_r)
        prcp_pkg::ST_IDLE:
        begin
          ph_r <= prcp_pkg::PH_0;
          if (go_r)
          begin
            state_r <= prcp_pkg::ST_START;
            stage_r <= cmd_r.i2c ? prcp_pkg::STG_ADDR : prcp_pkg::STG_REG;
            cnt_r <= '0;
            nack_r <= 1'b0;
            done_r <= 1'b0;
          end
        end
        prcp_pkg::ST_START:
        begin
          if (adv)
          begin
            case (ph_r)
              prcp_pkg::PH_0:
              begin
                pins_r.sda_oe <= 1'b0;
                pins_r.slave_select_n <= cmd_r.i2c;
              end
              prcp_pkg::PH_1: pins_r.scl_oe <= 1'b0;
              prcp_pkg::PH_2: pins_r.sda_oe <= cmd_r.i2c;
              default:
              begin
                pins_r.scl_oe <= cmd_r.i2c;
                sh_r <= byte_of(stage_r, cnt_r, cmd_r, txd_r);
                bit_r <= '0;
                state_r <= prcp_pkg::ST_BIT;
              end
            endcase
          end
        end
        prcp_pkg::ST_BIT:
        begin
          if (adv)
          begin
            case (ph_r)
              prcp_pkg::PH_0:
              begin
                // Clock idles low; data changes at the rising edge.
                if (cmd_r.i2c)
                begin
                  pins_r.sda_oe <= !tx_bit;
                end
                else
                begin
                  pins_r.sclk <= 1'b1;
                  pins_r.mosi <= tx_bit;
                end
              end
              prcp_pkg::PH_1: pins_r.scl_oe <= 1'b0;
              prcp_pkg::PH_2: pins_r.sclk <= 1'b0;
              default:
              begin
                pins_r.scl_oe <= cmd_r.i2c;
                bit_r <= bit_r + 4'h1;
                if (bit_r != prcp_pkg::BIT_LAST_I2C)
                begin
                  rxsh_r <= {rxsh_r[6:0], sbit};
                  sh_r <= {sh_r[6:0], 1'b1};
                end
                if (bit_r == bit_last)
                begin
                  bit_r <= '0;
                  if (cmd_r.i2c && !rx_data && sbit)
                  begin
                    // Missing acknowledge aborts with a stop.
                    nack_r <= 1'b1;
                    state_r <= prcp_pkg::ST_STOP;
                  end
                  else if (stage_r == prcp_pkg::STG_DATA && last_data)
                  begin
                    state_r <= prcp_pkg::ST_STOP;
                  end
                  else if (stage_nxt == prcp_pkg::STG_RADDR)
                  begin
                    stage_r <= stage_nxt;
                    state_r <= prcp_pkg::ST_START;
                  end
                  else
                  begin
                    // Select stays low across the burst.
                    stage_r <= stage_nxt;
                    if (stage_r == prcp_pkg::STG_DATA)
                    begin
                      cnt_r <= cnt_r + 2'h1;
                      sh_r <= byte_of(stage_r, cnt_r + 2'h1, cmd_r, txd_r);
                    end
                    else
                    begin
                      sh_r <= byte_of(stage_nxt, cnt_r, cmd_r, txd_r);
                    end
                  end
                end
              end
            endcase
          end
        end
        prcp_pkg::ST_STOP:
        begin
          if (adv)
          begin
            case (ph_r)
              prcp_pkg::PH_0: pins_r.sda_oe <= cmd_r.i2c;
              prcp_pkg::PH_1: pins_r.scl_oe <= 1'b0;
              prcp_pkg::PH_2: pins_r.sclk <= 1'b0;
              default:
              begin
                pins_r.sda_oe <= 1'b0;
                pins_r.slave_select_n <= 1'b1;
                pins_r.mosi <= 1'b0;
                state_r <= prcp_pkg::ST_IDLE;
                done_r <= 1'b1;
              end
            endcase
          end
        end
        default: state_r <= prcp_pkg::ST_IDLE;
      endcase
    end
  end

  // Received data bytes land in their lane of the read-back register.
  for (genvar g = 0; g < 4; g++)
  begin : g_rx
    always_ff @(posedge clock)
    begin
      if (sys_rst)
      begin
        rxd_r[g] <= '0;
      end
      else if (ce && cap && (cnt_r == 2'(g)))
      begin
        rxd_r[g] <= cap_byte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus: address and data are taken in either order.
  assign wr_fire = !awready_r && !wready_r && !bvalid_r;
  assign cmd_ok = !busy;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= prcp_pkg::RESP_OKAY;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      cmd_r <= prcp_pkg::CMD_RESET;
      txd_r <= '0;
      go_r <= 1'b0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && awready_r)
      begin
        awaddr_r <= s_axi_awaddr;
        awready_r <= 1'b0;
      end
      if (s_axi_wvalid && wready_r)
      begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        wready_r <= 1'b0;
      end
      if (state_r == prcp_pkg::ST_IDLE)
      begin
        go_r <= 1'b0;
      end
      if (wr_fire)
      begin
        bvalid_r <= 1'b1;
        bresp_r <= prcp_pkg::RESP_OKAY;
        case (awaddr_r)
          prcp_pkg::OFS_CMD:
          begin
            // A command while busy is refused so the frame in flight stays intact.
            if (cmd_ok)
            begin
              cmd_r <= merge(cmd_r, wdata_r, wstrb_r);
              go_r <= 1'b1;
            end
            else
            begin
              bresp_r <= prcp_pkg::RESP_SLVERR;
            end
          end
          prcp_pkg::OFS_TXD: txd_r <= merge(txd_r, wdata_r, wstrb_r);
          prcp_pkg::OFS_RXD, prcp_pkg::OFS_STS: bresp_r <= prcp_pkg::RESP_OKAY;
          default: bresp_r <= prcp_pkg::RESP_SLVERR;
        endcase
      end
      if (bvalid_r && s_axi_bready)
      begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  always_comb
  begin
    rd_map = 1'b1;
    case (s_axi_araddr)
      prcp_pkg::OFS_CMD: rd_val = cmd_r;
      prcp_pkg::OFS_TXD: rd_val = txd_r;
      prcp_pkg::OFS_RXD: rd_val = rxd_r;
      prcp_pkg::OFS_STS: rd_val = prcp_pkg::prcp_sts_s'({29'h0000_0000, done_r, nack_r, busy});
      default:
      begin
        rd_val = prcp_pkg::WORD_ZERO;
        rd_map = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rresp_r <= prcp_pkg::RESP_OKAY;
      rdata_r <= prcp_pkg::WORD_ZERO;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && arready_r)
      begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rdata_r <= rd_val;
        rresp_r <= rd_map ? prcp_pkg::RESP_OKAY : prcp_pkg::RESP_SLVERR;
      end
      else if (rvalid_r && s_axi_rready)
      begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign pins = pins_r;

endmodule

// file: dv/prcp_host_monitor.sv
// Port checker for the paged register control port host.
`timescale 1ns/100ps
module prcp_host_monitor (
  // Clock and reset.
  input wire logic clock,
  input wire logic sys_rst,
  // Register bus handshakes.
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Device pins.
  input wire prcp_pkg::prcp_pins_s pins
);
  default clocking mon_cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////
  // One bit holds the serial clock high for two quarters.
  sequence s_sclk_high;
    pins.sclk [*4] ##1 !pins.sclk;
  endsequence
  sequence s_first_bit;
    !pins.sclk ##[1:8] pins.sclk;
  endsequence

  a_sclk_idle: assert property (pins.slave_select_n |-> !pins.sclk)
    else $error("serial clock not low outside a frame");
  a_sclk_width: assert property ($rose(pins.sclk) |-> s_sclk_high)
    else $error("serial clock high time wrong");
  a_sel_lead: assert property ($fell(pins.slave_select_n) |-> s_first_bit)
    else $error("no clock edge soon after select fell");
  a_mosi_edge: assert property (
    $changed(pins.mosi) && !pins.slave_select_n && !$past(pins.slave_select_n)
    |-> $rose(pins.sclk))
    else $error("data out changed away from the leading clock edge");
  a_bus_excl: assert property (
    !pins.slave_select_n |-> !pins.scl_oe && !pins.sda_oe)
    else $error("two-wire lines pulled during a select frame");
  a_b_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write response late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_w_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
endmodule

bind prcp_host prcp_host_monitor u_prcp_host_monitor (
  .clock(clock), .sys_rst(sys_rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .pins(pins)
);

// file: dv/prcp_dev_model.sv
// Behavioural model of the paged register device behind its select-framed port.
`timescale 1ns/100ps
module prcp_dev_model (
  // Serial port pins.
  input wire logic slave_select_n,
  input wire logic sclk,
  input wire logic mosi,
  output logic miso
);
  // Eight pages of 128 bytes; higher page numbers alias, the bench keeps off them.
  logic [7:0] mem_r [0:1023];
  logic [7:0] page_r;
  logic [7:0] sh_r;
  logic [7:0] tx_r;
  logic [6:0] addr_r;
  logic rd_r;
  logic cmd_r;
  logic bit_r;
  int cnt_r;

  task automatic poke(input logic [6:0] a, input logic [7:0] v);
    if (a == prcp_pkg::DEV_PAGE_SELECT)
      page_r = v;
    else if (page_r != prcp_pkg::PAGE_CONFIG || (a != prcp_pkg::DEV_AUDIO_BUS_CLOCK_MONITOR
             && a != prcp_pkg::DEV_IO_PIN_MONITOR))
      mem_r[{page_r[2:0], a}] = v;
  endtask

  initial
  begin
    page_r = 8'h00;
    foreach (mem_r[i])
      mem_r[i] = 8'h00;
    bit_r = 1'b0;
    cnt_r = 0;
  end

  ////////////////////////////////////////////////////////////
  // Only the latest falling select counts, so a long low select is harmless.
  always @(negedge slave_select_n)
  begin
    cnt_r = 0;
    cmd_r = 1'b1;
    tx_r = 8'h00;
  end

  always @(posedge sclk)
    if (!slave_select_n)
    begin
      bit_r = tx_r[7];
      tx_r = {tx_r[6:0], 1'b0};
    end

  always @(negedge sclk)
    if (!slave_select_n)
    begin
      sh_r = {sh_r[6:0], mosi};
      cnt_r++;
      if (cnt_r == 8)
      begin
        cnt_r = 0;
        if (cmd_r)
        begin
          addr_r = sh_r[7:1];
          rd_r = sh_r[0];
          cmd_r = 1'b0;
        end
        else
        begin
          if (!rd_r)
            poke(addr_r, sh_r);
          addr_r = addr_r + 7'h01;
        end
        if (rd_r)
          tx_r = (addr_r == 7'h00) ? page_r : mem_r[{page_r[2:0], addr_r}];
      end
    end

  // A released data line shows no stale level; it flips instead.
  assign miso = slave_select_n ? ~bit_r : bit_r;
endmodule

// file: dv/prcp_host_bench.sv
// Self-checking bench for the paged register control port host.
`timescale 1ns/100ps
module prcp_host_bench;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic awr, wr, bv, arr, rv, miso;
  logic [1:0] bresp, rresp;
  logic [31:0] rd;
  logic [34:0] ent;
  logic [1:0] exp_b [$];
  logic [34:0] exp_r [$];
  int err_total = 0;
  int compares = 0;
  prcp_pkg::prcp_pins_s pins;
  prcp_pkg::prcp_pin_in_s pin_in;

  always #50 clock = ~clock;
  // Pull-ups only on the two-wire lines: nobody acknowledges there.
  assign pin_in = {miso, ~pins.scl_oe, ~pins.sda_oe};

  prcp_host u_prcp_host (
    .clock(clock), .ce(1'b1), .sys_rst(sys_rst),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brd),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrd),
    .pins_in(pin_in), .pins(pins));
  prcp_dev_model u_prcp_dev_model (.slave_select_n(pins.slave_select_n),
    .sclk(pins.sclk), .mosi(pins.mosi), .miso(miso));

  ////////////////////////////////////////////////////////////
  task automatic cmp_resp(input string n, input logic [1:0] e, input logic [1:0] s);
    compares++;
    if (s !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic cmp_data(input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e)
    begin
      err_total++;
      $display("Error rdata expected %h seen %h", e, s);
    end
  endtask

  always @(posedge clock)
  begin
    if (bv && brd)
      cmp_resp("bresp", exp_b.pop_front(), bresp);
    if (rv && rrd)
    begin
      ent = exp_r.pop_front();
      if (ent[34])
      begin
        cmp_resp("rresp", ent[33:32], rresp);
        cmp_data(ent[31:0], rd);
      end
    end
  end

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    exp_b.push_back(er);
    @(posedge clock);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brd <= 1'b1;
    do
    begin
      @(posedge clock);
      if (awr)
        awv <= 1'b0;
      if (wr)
        wv <= 1'b0;
    end
    while (awv && !awr || wv && !wr);
    while (!bv)
      @(posedge clock);
    brd <= 1'b0;
  endtask

  // A clear mark bit turns the read into a poll whose data is not compared.
  task automatic axi_rd(input logic [7:0] a, input logic m, input logic [1:0] er,
                        input logic [31:0] ed, output logic [31:0] d);
    exp_r.push_back({m, er, ed});
    @(posedge clock);
    ara <= a;
    arv <= 1'b1;
    rrd <= 1'b1;
    do
      @(posedge clock);
    while (!arr);
    arv <= 1'b0;
    do
      @(posedge clock);
    while (!rv);
    d = rd;
    rrd <= 1'b0;
  endtask

  // Busy is already set when the command's write response arrives; see it set, then wait it out.
  task automatic xfer(input logic i2c, input logic r, input logic [6:0] ra,
                      input logic [1:0] lm, input logic dbl);
    prcp_pkg::prcp_cmd_s c;
    logic [31:0] d;
    c = '0;
    c.reg_addr = ra;
    c.rd = r;
    c.len_m1 = lm;
    c.i2c = i2c;
    c.strap = 2'($urandom_range(3));
    axi_wr(prcp_pkg::OFS_CMD, c, prcp_pkg::RESP_OKAY);
    if (dbl)
      axi_wr(prcp_pkg::OFS_CMD, 32'(c) & 32'hffff_ff80, prcp_pkg::RESP_SLVERR);
    d = 32'h0000_0000;
    while (!d[0])
      axi_rd(prcp_pkg::OFS_STS, 1'b0, 2'h0, 32'h0000_0000, d);
    while (d[0])
      axi_rd(prcp_pkg::OFS_STS, 1'b0, 2'h0, 32'h0000_0000, d);
  endtask

  task automatic page(input logic [7:0] p);
    axi_wr(prcp_pkg::OFS_TXD, {24'h00_0000, p}, prcp_pkg::RESP_OKAY);
    xfer(1'b0, 1'b0, prcp_pkg::DEV_PAGE_SELECT, 2'h0, 1'b0);
  endtask

  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    logic [31:0] d;
    logic [31:0] tx [2:4];
    void'($urandom(70457));
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    axi_rd(prcp_pkg::OFS_STS, 1'b1, prcp_pkg::RESP_OKAY, 32'h0000_0000, d);
    axi_rd(8'h10, 1'b1, prcp_pkg::RESP_SLVERR, 32'h0000_0000, d);
    axi_wr(prcp_pkg::OFS_STS, 32'hffff_ffff, prcp_pkg::RESP_OKAY);
    axi_rd(prcp_pkg::OFS_STS, 1'b1, prcp_pkg::RESP_OKAY, 32'h0000_0000, d);
    xfer(1'b0, 1'b1, prcp_pkg::DEV_PAGE_SELECT, 2'h3, 1'b0);
    axi_rd(prcp_pkg::OFS_RXD, 1'b1, prcp_pkg::RESP_OKAY, 32'h0000_0000, d);
    for (int p = 2; p <= 4; p++)
    begin
      page(8'(p));
      tx[p] = $urandom();
      axi_wr(prcp_pkg::OFS_TXD, tx[p], prcp_pkg::RESP_OKAY);
      xfer(1'b0, 1'b0, 7'h7c, 2'h3, 1'b1);
    end
    for (int p = 2; p <= 4; p++)
    begin
      page(8'(p));
      xfer(1'b0, 1'b1, 7'h7c, 2'h3, 1'b0);
      axi_rd(prcp_pkg::OFS_RXD, 1'b1, prcp_pkg::RESP_OKAY, tx[p], d);
      xfer(1'b0, 1'b1, prcp_pkg::DEV_PAGE_SELECT, 2'h3, 1'b0);
      axi_rd(prcp_pkg::OFS_RXD, 1'b1, prcp_pkg::RESP_OKAY, 32'(p), d);
    end
    page(prcp_pkg::PAGE_CONFIG);
    xfer(1'b0, 1'b1, 7'h7c, 2'h3, 1'b0);
    axi_rd(prcp_pkg::OFS_RXD, 1'b1, prcp_pkg::RESP_OKAY, 32'h0000_0000, d);
    xfer(1'b1, 1'b1, prcp_pkg::DEV_SLEEP_CONTROL, 2'h0, 1'b0);
    axi_rd(prcp_pkg::OFS_STS, 1'b1, prcp_pkg::RESP_OKAY, 32'h0000_0006, d);
    xfer(1'b0, 1'b1, prcp_pkg::DEV_PAGE_SELECT, 2'h0, 1'b0);
    axi_rd(prcp_pkg::OFS_STS, 1'b1, prcp_pkg::RESP_OKAY, 32'h0000_0004, d);
    end_sim();
  end

  initial
  begin
    repeat (60000) @(posedge clock);
    err_total++;
    end_sim();
  end
endmodule
